// ==== ebp_port.sv ====
// external bus port: master cycles, slave access and decoded selects
`timescale 1ns/100ps
`default_nettype none
module ebp_port
  import ebp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  // external bus pins
  input wire logic [ADDR_W-1:0] ext_address_bus_i,
  output logic [ADDR_W-1:0] ext_address_bus_o,
  output logic ext_address_bus_oe,
  input wire logic [DATA_W-1:0] ext_data_bus_i,
  output logic [DATA_W-1:0] ext_data_bus_o,
  output logic ext_data_bus_oe,
  input wire logic read_strobe_n_i,
  output logic read_strobe_n_o,
  input wire logic write_low_strobe_n_i,
  output logic write_low_strobe_n_o,
  input wire logic write_high_strobe_n_i,
  output logic write_high_strobe_n_o,
  output logic strobe_oe,
  input wire logic ack_n_i,
  output logic ack_n_o,
  output logic ack_oe,
  input wire logic burst_indicator_n_i,
  output logic burst_indicator_n_o,
  output logic burst_indicator_oe,
  input wire logic boot_mem_select_n_i,
  output logic boot_mem_select_n_o,
  output logic bank0_select_n,
  output logic bank1_select_n,
  output logic host_space_select_n,
  output logic select_oe,
  input wire logic bus_master_own,
  input wire logic host_grant_n,
  output logic boot_source_strap,
  // master request side
  input wire logic mst_req_valid,
  output logic mst_req_ready,
  input wire logic mst_req_write,
  input wire logic [ADDR_W-1:0] mst_req_addr,
  input wire logic [DATA_W-1:0] mst_req_data,
  input wire logic mst_req_long,
  input wire logic mst_req_zone32,
  input wire logic mst_req_sdram,
  input wire logic mst_req_boot,
  input wire logic mst_req_burst_more,
  output logic mst_rd_valid,
  output logic [DATA_W-1:0] mst_rd_data,
  // slave side toward internal memory
  output logic slv_wr_valid,
  input wire logic slv_wr_ready,
  output logic [ADDR_W-1:0] slv_wr_addr,
  output logic [DATA_W-1:0] slv_wr_data,
  output logic slv_wr_low,
  output logic slv_wr_high,
  output logic slv_rd_req,
  output logic [ADDR_W-1:0] slv_rd_addr,
  input wire logic slv_rd_valid,
  input wire logic [DATA_W-1:0] slv_rd_data
);
  logic [SYNC_W-1:0] sync_s1_ff;
  logic [SYNC_W-1:0] sync_s2_ff;
  ebp_mst_e mst_st_ff;
  ebp_mst_e nxt_mst_st;
  ebp_slv_e slv_st_ff;
  ebp_slv_e nxt_slv_st;
  logic [1:0] settle_ff;
  logic burst_more_ff;
  logic mst_is_write_ff;
  logic rd_p_ff;
  logic wr_p_ff;
  logic [ADDR_W-1:0] burst_cnt_ff;
  logic burst_cnt_vld_ff;
  logic [FE_W-1:0] ent_ff;
  logic fifo_in_ready;
  logic [FE_W-1:0] fifo_out;
  logic fifo_out_valid;

  // two-flop synchroniser for every pin input, free running so the strap is seen in reset
  always_ff @(posedge clk_sys)
  begin
    sync_s1_ff <= {ext_address_bus_i, ext_data_bus_i, read_strobe_n_i,
                   write_low_strobe_n_i, write_high_strobe_n_i, ack_n_i,
                   burst_indicator_n_i, boot_mem_select_n_i, bus_master_own,
                   host_grant_n};
    sync_s2_ff <= sync_s1_ff;
  end

  // views of the synchronised pins
  wire [ADDR_W-1:0] addr_s = sync_s2_ff[SY_ADDR_LSB +: ADDR_W];
  wire [DATA_W-1:0] data_s = sync_s2_ff[SY_DATA_LSB +: DATA_W];
  wire rd_n_s = sync_s2_ff[SY_RD];
  wire wrl_n_s = sync_s2_ff[SY_WRL];
  wire wrh_n_s = sync_s2_ff[SY_WRH];
  wire ack_n_s = sync_s2_ff[SY_ACK];
  wire burst_indicator_n_s = sync_s2_ff[SY_BURST_INDICATOR];
  wire bms_s = sync_s2_ff[SY_BMS];
  wire drive_en = sync_s2_ff[SY_MASTER] & sync_s2_ff[SY_GRANT];

  // master request decode
  wire acc = mst_req_valid & mst_req_ready;
  wire wr_low_need = mst_req_write & (~mst_req_addr[0] | mst_req_zone32);
  wire wr_high_need = mst_req_write & ~mst_req_zone32
                      & (mst_req_long | mst_req_addr[0]);
  wire rd_need = ~mst_req_write & ~mst_req_sdram;
  wire [4:0] req_top = mst_req_addr[SEL_MSB:SEL_LSB];
  wire dec_bank0 = (req_top == BANK0_PAT);
  wire dec_bank1 = (req_top == BANK1_PAT);
  wire dec_host = mst_req_addr[HOST_BIT];
  wire ack_seen = (mst_st_ff == M_WAIT) & (settle_ff == ACK_SETTLE) & ~ack_n_s;

  // master state sequencing
  always_comb
  begin
    nxt_mst_st = mst_st_ff;
    case (mst_st_ff)
      M_IDLE:
      begin
        if (acc)
        begin
          nxt_mst_st = M_WAIT;
        end
      end
      M_WAIT:
      begin
        if (ack_seen)
        begin
          nxt_mst_st = M_DONE;
        end
      end
      M_DONE: nxt_mst_st = M_IDLE;
      default: nxt_mst_st = M_IDLE;
    endcase
  end

  // slave strobe edges on the synchronised pins
  wire wr_any = ~wrl_n_s | ~wrh_n_s;
  wire slv_hit = ~drive_en & (addr_s[SEL_MSB:SEL_LSB] == SLV_WIN_PAT);
  wire wr_edge = slv_hit & wr_any & ~wr_p_ff;
  wire rd_edge = slv_hit & ~rd_n_s & rd_p_ff;
  wire strobes_off = rd_n_s & wrl_n_s & wrh_n_s;
  wire use_cnt = ~burst_indicator_n_s & burst_cnt_vld_ff;
  wire [ADDR_W-1:0] tgt_addr = use_cnt ? burst_cnt_ff : addr_s;
  wire slv_start = (slv_st_ff == S_IDLE) & (wr_edge | rd_edge);

  // slave state sequencing
  always_comb
  begin
    nxt_slv_st = slv_st_ff;
    case (slv_st_ff)
      S_IDLE:
      begin
        if (wr_edge)
        begin
          nxt_slv_st = S_WR;
        end
        else if (rd_edge)
        begin
          nxt_slv_st = S_RD;
        end
      end
      S_WR:
      begin
        if (fifo_in_ready)
        begin
          nxt_slv_st = S_END;
        end
      end
      S_RD:
      begin
        if (slv_rd_valid)
        begin
          nxt_slv_st = S_END;
        end
      end
      S_END:
      begin
        if (strobes_off | drive_en)
        begin
          nxt_slv_st = S_IDLE;
        end
      end
      default: nxt_slv_st = S_IDLE;
    endcase
  end

  // state registers and small counters
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      mst_st_ff <= M_IDLE;
      slv_st_ff <= S_IDLE;
      settle_ff <= '0;
      rd_p_ff <= STROBE_OFF;
      wr_p_ff <= 1'b0;
    end
    else
    begin
      mst_st_ff <= nxt_mst_st;
      slv_st_ff <= nxt_slv_st;
      settle_ff <= (mst_st_ff != M_WAIT) ? 2'h0 : settle_ff + 2'(settle_ff != ACK_SETTLE);
      rd_p_ff <= rd_n_s;
      wr_p_ff <= wr_any;
    end
  end

  // address, strobes and selects all load on one edge
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      ext_address_bus_o <= ADDR_RST;
      read_strobe_n_o <= STROBE_OFF;
      write_low_strobe_n_o <= STROBE_OFF;
      write_high_strobe_n_o <= STROBE_OFF;
      bank0_select_n <= STROBE_OFF;
      bank1_select_n <= STROBE_OFF;
      host_space_select_n <= STROBE_OFF;
      boot_mem_select_n_o <= STROBE_OFF;
      mst_is_write_ff <= 1'b0;
    end
    else if (acc)
    begin
      ext_address_bus_o <= mst_req_addr;
      read_strobe_n_o <= ~rd_need;
      write_low_strobe_n_o <= ~wr_low_need;
      write_high_strobe_n_o <= ~wr_high_need;
      bank0_select_n <= ~dec_bank0;
      bank1_select_n <= ~dec_bank1;
      host_space_select_n <= ~dec_host;
      boot_mem_select_n_o <= ~mst_req_boot;
      mst_is_write_ff <= mst_req_write;
    end
    else if (mst_st_ff == M_DONE)
    begin
      read_strobe_n_o <= STROBE_OFF;
      write_low_strobe_n_o <= STROBE_OFF;
      write_high_strobe_n_o <= STROBE_OFF;
      bank0_select_n <= STROBE_OFF;
      bank1_select_n <= STROBE_OFF;
      host_space_select_n <= STROBE_OFF;
      boot_mem_select_n_o <= STROBE_OFF;
    end
  end

  // burst indicator held across consecutive master transfers
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      burst_indicator_n_o <= STROBE_OFF;
      burst_more_ff <= 1'b0;
    end
    else if (acc)
    begin
      burst_indicator_n_o <= ~(mst_req_burst_more | burst_more_ff);
      burst_more_ff <= mst_req_burst_more;
    end
    else if ((mst_st_ff == M_DONE) && !burst_more_ff)
    begin
      burst_indicator_n_o <= STROBE_OFF;
    end
  end

  // output enables and master handshake
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      ext_address_bus_oe <= 1'b0;
      strobe_oe <= 1'b0;
      select_oe <= 1'b0;
      burst_indicator_oe <= 1'b0;
      mst_req_ready <= 1'b0;
      ack_oe <= 1'b0;
      ack_n_o <= STROBE_OFF;
    end
    else
    begin
      ext_address_bus_oe <= drive_en;
      strobe_oe <= drive_en;
      select_oe <= drive_en;
      burst_indicator_oe <= drive_en;
      mst_req_ready <= drive_en & (nxt_mst_st == M_IDLE) & ~acc;
      ack_oe <= (nxt_slv_st != S_IDLE);
      ack_n_o <= (nxt_slv_st != S_END);
    end
  end

  // shared data pins: master write data or slave read data
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      ext_data_bus_o <= DATA_RST;
      ext_data_bus_oe <= 1'b0;
    end
    else if (acc)
    begin
      ext_data_bus_o <= mst_req_data;
      ext_data_bus_oe <= drive_en & mst_req_write;
    end
    else if ((slv_st_ff == S_RD) && slv_rd_valid)
    begin
      ext_data_bus_o <= slv_rd_data;
      ext_data_bus_oe <= 1'b1;
    end
    else if ((mst_st_ff == M_DONE) || (!drive_en && (slv_st_ff == S_IDLE))
             || ((slv_st_ff == S_END) && (nxt_slv_st == S_IDLE)))
    begin
      ext_data_bus_oe <= 1'b0;
    end
  end

  // master read capture
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      mst_rd_valid <= 1'b0;
      mst_rd_data <= DATA_RST;
    end
    else
    begin
      mst_rd_valid <= ack_seen & ~mst_is_write_ff;
      if (ack_seen && !mst_is_write_ff)
      begin
        mst_rd_data <= data_s;
      end
    end
  end

  // slave address counter, write entry and read request
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      burst_cnt_ff <= ADDR_RST;
      burst_cnt_vld_ff <= 1'b0;
      ent_ff <= '0;
      slv_rd_req <= 1'b0;
      slv_rd_addr <= ADDR_RST;
    end
    else
    begin
      slv_rd_req <= slv_start & ~wr_edge;
      if (slv_start)
      begin
        burst_cnt_ff <= tgt_addr + ADDR_W'(1);
        burst_cnt_vld_ff <= ~burst_indicator_n_s;
        ent_ff <= {tgt_addr, data_s, ~wrl_n_s, ~wrh_n_s};
        slv_rd_addr <= tgt_addr;
      end
      else if (burst_indicator_n_s && slv_st_ff == S_IDLE)
      begin
        burst_cnt_vld_ff <= 1'b0;
      end
    end
  end

  // boot mode strap caught while reset is held
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      boot_source_strap <= bms_s;
    end
  end

  // slave write buffer toward internal memory
  ebp_fifo #(
    .WIDTH(FE_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .in_valid(slv_st_ff == S_WR),
    .in_ready(fifo_in_ready),
    .in_data(ent_ff),
    .out_valid(fifo_out_valid),
    .out_ready(slv_wr_ready),
    .out_data(fifo_out)
  );
  assign slv_wr_valid = fifo_out_valid;
  assign {slv_wr_addr, slv_wr_data, slv_wr_low, slv_wr_high} = fifo_out;

  // checks on the driven pins, the boot strap and the slave burst counter
  property p_rd_strobe;
    @(posedge clk_sys) disable iff (!rstn)
    acc && rd_need |=> !read_strobe_n_o && (ext_address_bus_o == $past(mst_req_addr));
  endproperty
  a_rd_strobe: assert property (p_rd_strobe) else $error("read strobe missing");
  property p_wrl;
    @(posedge clk_sys) disable iff (!rstn)
    acc && wr_low_need |=> !write_low_strobe_n_o ##1 !write_low_strobe_n_o;
  endproperty
  a_wrl: assert property (p_wrl) else $error("write low wrong");
  property p_wrh;
    @(posedge clk_sys) disable iff (!rstn)
    acc && mst_req_write && !wr_high_need |=> write_high_strobe_n_o;
  endproperty
  a_wrh: assert property (p_wrh) else $error("write high wrong");
  property p_bank0;
    @(posedge clk_sys) disable iff (!rstn)
    acc && dec_bank0 |=> !bank0_select_n && bank1_select_n
      && (ext_address_bus_o[SEL_MSB:SEL_LSB] == BANK0_PAT);
  endproperty
  a_bank0: assert property (p_bank0) else $error("bank0 select wrong");
  property p_bank1;
    @(posedge clk_sys) disable iff (!rstn)
    !bank1_select_n |-> ext_address_bus_o[SEL_MSB:SEL_LSB] == BANK1_PAT;
  endproperty
  a_bank1: assert property (p_bank1) else $error("bank1 select wrong");
  property p_host;
    @(posedge clk_sys) disable iff (!rstn)
    !host_space_select_n |-> ext_address_bus_o[HOST_BIT];
  endproperty
  a_host: assert property (p_host) else $error("host select wrong");
  property p_release;
    @(posedge clk_sys) disable iff (!rstn)
    !sync_s2_ff[SY_GRANT] |=> !ext_address_bus_oe && !strobe_oe && !select_oe;
  endproperty
  a_release: assert property (p_release) else $error("bus not released");
  property p_strap;
    @(posedge clk_sys)
    !rstn ##1 rstn |-> boot_source_strap == $past(bms_s);
  endproperty
  a_strap: assert property (p_strap) else $error("strap not caught");
  property p_burst_cnt;
    @(posedge clk_sys) disable iff (!rstn)
    slv_start && use_cnt |=> burst_cnt_ff == $past(burst_cnt_ff) + ADDR_W'(1);
  endproperty
  a_burst_cnt: assert property (p_burst_cnt) else $error("burst count stuck");
  property p_wait;
    @(posedge clk_sys) disable iff (!rstn)
    slv_st_ff == S_RD && !slv_rd_valid |=> ack_oe && ack_n_o;
  endproperty
  a_wait: assert property (p_wait) else $error("no wait state");
endmodule // ebp_port
`default_nettype wire

// ==== ebp_pkg.sv ====
// constants and state types of the external bus port
// What this block does
// - drive address as master, accept as slave
// - drive and receive 64-bit data bus
// - read strobe on every non-SDRAM read
// - read strobe is slave read input
// - strobes change together with the address
// - write-low for even word or 32-bit zone
// - write-high for long or odd word outside 32-bit zone
// - write strobes are slave write inputs
// - as slave, withhold acknowledge for waits
// - boot select is boot memory chip select
// - boot select pin sampled in reset as strap
// - bank-0 select when address top is 00110
// - bank-1 select when address top is 00111
// - host-space select when address bit 31 set
// - only current master drives address, strobes, selects and burst; as slave it drives acknowledge and read data
// - master asserts burst on consecutive addresses
// - slave bursts increment target address per transfer
// - release all outputs when host is granted
// - everything timed by the system clock
package ebp_pkg;
  localparam int ADDR_W = 32;
  localparam int DATA_W = 64;
  localparam int FIFO_DEPTH = 16;
  localparam int FE_W = ADDR_W + DATA_W + 2;
  localparam int SYNC_W = ADDR_W + DATA_W + 8;
  // bit positions inside the synchroniser vector
  localparam int SY_GRANT = 0;
  localparam int SY_MASTER = 1;
  localparam int SY_BMS = 2;
  localparam int SY_BURST_INDICATOR = 3;
  localparam int SY_ACK = 4;
  localparam int SY_WRH = 5;
  localparam int SY_WRL = 6;
  localparam int SY_RD = 7;
  localparam int SY_DATA_LSB = 8;
  localparam int SY_ADDR_LSB = 72;
  // address decode
  localparam int SEL_MSB = 31;
  localparam int SEL_LSB = 27;
  localparam logic [4:0] BANK0_PAT = 5'h06;
  localparam logic [4:0] BANK1_PAT = 5'h07;
  localparam logic [4:0] SLV_WIN_PAT = 5'h00;
  localparam int HOST_BIT = 31;
  // cycles before a synchronised acknowledge is trusted
  localparam logic [1:0] ACK_SETTLE = 2'h3;
  localparam logic STROBE_OFF = 1'b1;
  localparam logic [ADDR_W-1:0] ADDR_RST = 32'h0000_0000;
  localparam logic [DATA_W-1:0] DATA_RST = 64'h0;
  typedef enum logic [2:0] {
    M_IDLE = 3'b001,
    M_WAIT = 3'b010,
    M_DONE = 3'b100
  } ebp_mst_e;
  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_WR = 4'b0010,
    S_RD = 4'b0100,
    S_END = 4'b1000
  } ebp_slv_e;
endpackage

// ==== ebp_fifo.sv ====
// parameterised first-in first-out buffer with valid and ready
`timescale 1ns/100ps
`default_nettype none
module ebp_fifo
  import ebp_pkg::*;
#(
  parameter int WIDTH = FE_W,
  parameter int DEPTH = FIFO_DEPTH
)(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [AW:0] cnt_ff;
  logic [AW:0] nxt_cnt;
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;

  // flags straight from the occupancy count
  assign in_ready = (cnt_ff != (AW+1)'(DEPTH));
  assign out_valid = (cnt_ff != '0);
  assign out_data = mem_ff[rd_ptr_ff];
  assign nxt_cnt = cnt_ff + (AW+1)'(push) - (AW+1)'(pop);

  // storage array, no reset needed
  always_ff @(posedge clk_sys)
  begin
    if (push)
    begin
      mem_ff[wr_ptr_ff] <= in_data;
    end
  end

  // pointers and count
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      cnt_ff <= '0;
    end
    else
    begin
      wr_ptr_ff <= wr_ptr_ff + AW'(push);
      rd_ptr_ff <= rd_ptr_ff + AW'(pop);
      cnt_ff <= nxt_cnt;
    end
  end
endmodule // ebp_fifo
`default_nettype wire

// ==== ebp_mem_model.sv ====
// external memory model answering master cycles with wait states
`timescale 1ns/100ps
`default_nettype none
module ebp_mem_model
  import ebp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] data,
  input wire logic [7:0] pins,
  input wire logic [1:0] wait_cyc,
  output logic ack_n,
  output logic ack_oe,
  output logic [DATA_W-1:0] dat_o,
  output logic dat_oe,
  output logic [ADDR_W-1:0] seen_addr_ff,
  output logic [DATA_W-1:0] seen_data_ff,
  output logic [7:0] seen_pins_ff
);
  logic busy_ff;
  logic [1:0] cnt_ff;
  logic [1:0] wait_ff;
  // selected when a strobe and a select are both low
  wire logic hit = !(&pins[2:0]) && !(&{pins[7], pins[5:3]});
  wire logic done = busy_ff && cnt_ff == wait_ff;
  // acknowledge withheld for the chosen wait states, read data only once acked
  assign ack_oe = busy_ff;
  assign ack_n = !done;
  assign dat_oe = done && !pins[2];
  assign dat_o = {~seen_addr_ff, seen_addr_ff};
  // latch the first cycle, count waits, drop out when strobes lift
  always_ff @(posedge clk_sys)
  begin
    if (!rstn || !hit)
    begin
      busy_ff <= 1'b0;
      cnt_ff <= 2'h0;
    end
    else if (!busy_ff)
    begin
      busy_ff <= 1'b1;
      wait_ff <= wait_cyc;
      seen_addr_ff <= addr;
      seen_pins_ff <= pins;
    end
    else
    begin
      cnt_ff <= done ? cnt_ff : cnt_ff + 2'h1;
      seen_data_ff <= data;
    end
  end
endmodule // ebp_mem_model
`default_nettype wire

// ==== tb_ebp_port.sv ====
// self-checking bench of the external bus port
`timescale 1ns/100ps
`default_nettype none
module tb_ebp_port
  import ebp_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic [31:0] rng = 32'h0000F096;
  logic [31:0] ta = 32'h0, ma = 32'h0, ea = 32'h0;
  logic [63:0] td = 64'h0, md = 64'h0, srd = 64'h0;
  logic trd = 1'b1, twl = 1'b1, twh = 1'b1, tbr = 1'b1, toe = 1'b0, tdoe = 1'b0;
  logic tbms = 1'b0, own = 1'b1, hgn = 1'b1, mv = 1'b0, mw = 1'b0, ml = 1'b0;
  logic mz = 1'b0, msd = 1'b0, mb = 1'b0, mm = 1'b0, swr = 1'b0, srv = 1'b0;
  logic pm = 1'b0, pb = 1'b0;
  logic [1:0] wc = 2'h0;
  logic [97:0] q [$];
  int error_cnt = 0, compares = 0, cyc = 0;
  logic [31:0] ca [6] = '{32'h3000_0002, 32'h3000_0003, 32'h3800_0004, 32'h8000_0006,
    32'h0000_1000, 32'h3800_0011};
  logic [4:0] cf [6] = '{5'h0B, 5'h01, 5'h05, 5'h01, 5'h10, 5'h00};
  wire logic [31:0] a_o, swa, sra, p_sa;
  wire logic [63:0] d_o, mrd, swd, p_d, p_sd;
  wire logic a_oe, d_oe, rd_o, wl_o, wh_o, s_oe, k_o, k_oe, b_o, b_oe, bms_o, b0, b1, hs;
  wire logic sel_oe, strap, mrdy, mrv, swv, swl, swh, srq, p_k, p_koe, p_doe;
  wire logic [7:0] p_sp;
  // wire levels resolved from every driver, pull-ups when released
  wire logic [31:0] a_w = a_oe ? a_o : (toe ? ta : '1);
  wire logic [63:0] d_w = d_oe ? d_o : (p_doe ? p_d : (tdoe ? td : '1));
  wire logic rd_w = s_oe ? rd_o : (toe ? trd : 1'b1);
  wire logic wl_w = s_oe ? wl_o : (toe ? twl : 1'b1);
  wire logic wh_w = s_oe ? wh_o : (toe ? twh : 1'b1);
  wire logic k_w = k_oe ? k_o : (p_koe ? p_k : 1'b1);
  wire logic b_w = b_oe ? b_o : (toe ? tbr : 1'b1);
  // strap resistor only holds the boot select at tbms while reset is applied
  wire logic bms_w = sel_oe ? bms_o : (rstn ? 1'b1 : tbms);
  wire logic [7:0] pw = {bms_w, b_w, sel_oe ? {b0, b1, hs} : 3'h7, rd_w, wl_w, wh_w};
  wire logic [5:0] oes = {a_oe, d_oe, s_oe, k_oe, b_oe, sel_oe};
  ebp_port i_ebp_port (
    .clk_sys(clk_sys), .rstn(rstn), .ext_address_bus_i(a_w), .ext_address_bus_o(a_o),
    .ext_address_bus_oe(a_oe), .ext_data_bus_i(d_w), .ext_data_bus_o(d_o),
    .ext_data_bus_oe(d_oe), .read_strobe_n_i(rd_w), .read_strobe_n_o(rd_o),
    .write_low_strobe_n_i(wl_w), .write_low_strobe_n_o(wl_o), .write_high_strobe_n_i(wh_w),
    .write_high_strobe_n_o(wh_o), .strobe_oe(s_oe), .ack_n_i(k_w), .ack_n_o(k_o),
    .ack_oe(k_oe), .burst_indicator_n_i(b_w), .burst_indicator_n_o(b_o),
    .burst_indicator_oe(b_oe), .boot_mem_select_n_i(bms_w), .boot_mem_select_n_o(bms_o),
    .bank0_select_n(b0), .bank1_select_n(b1), .host_space_select_n(hs), .select_oe(sel_oe),
    .bus_master_own(own), .host_grant_n(hgn), .boot_source_strap(strap),
    .mst_req_valid(mv), .mst_req_ready(mrdy), .mst_req_write(mw), .mst_req_addr(ma),
    .mst_req_data(md), .mst_req_long(ml), .mst_req_zone32(mz), .mst_req_sdram(msd),
    .mst_req_boot(mb), .mst_req_burst_more(mm), .mst_rd_valid(mrv), .mst_rd_data(mrd),
    .slv_wr_valid(swv), .slv_wr_ready(swr), .slv_wr_addr(swa), .slv_wr_data(swd),
    .slv_wr_low(swl), .slv_wr_high(swh), .slv_rd_req(srq), .slv_rd_addr(sra),
    .slv_rd_valid(srv), .slv_rd_data(srd));
  ebp_mem_model i_ebp_mem_model (
    .clk_sys(clk_sys), .rstn(rstn), .addr(a_w), .data(d_w), .pins(pw), .wait_cyc(wc),
    .ack_n(p_k), .ack_oe(p_koe), .dat_o(p_d), .dat_oe(p_doe), .seen_addr_ff(p_sa),
    .seen_data_ff(p_sd), .seen_pins_ff(p_sp));
  // clock, internal memory answer and hang limit
  always #2 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
  begin
    srv <= srq;
    srd <= {~sra, sra};
    cyc++;
    if (cyc == 5000)
    begin
      error_cnt++;
      finish_test();
    end
  end
  function automatic logic [31:0] xs();
    logic [31:0] s;
    s = rng;
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    compares++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // watched level: 0 master ready, 1 acknowledge pin, 2 acknowledge enable
  function automatic logic lvl_of(input int w);
    return (w == 0) ? mrdy : ((w == 1) ? k_w : k_oe);
  endfunction
  task automatic wait_lvl(input int w, input logic lvl);
    int n;
    n = 0;
    do
    begin
      @(negedge clk_sys);
      n++;
    end
    while (lvl_of(w) !== lvl && n < 100);
  endtask
  // one master transfer; f = boot, burst more, zone32, long, write
  task automatic m_xfer(input logic [31:0] a, input logic [4:0] f);
    logic [63:0] d;
    logic [7:0] ex;
    logic got;
    rng = xs();
    d = {~rng, rng ^ a};
    ex = {~f[4], ~(f[3] | pm), a[31:27] != 5'h06, a[31:27] != 5'h07, ~a[31], f[0],
      ~(f[0] & (~a[0] | f[2])), ~(f[0] & ~f[2] & (f[1] | a[0]))};
    pm = f[3];
    got = 1'b0;
    @(posedge clk_sys);
    wc <= rng[1:0];
    mv <= 1'b1;
    ma <= a;
    md <= d;
    {mb, mm, mz, ml, mw} <= f;
    wait_lvl(0, 1'b1);
    @(posedge clk_sys);
    mv <= 1'b0;
    @(posedge clk_sys);
    for (int n = 0; n < 100 && mrdy !== 1'b1; n++)
    begin
      @(negedge clk_sys);
      got |= (mrv === 1'b1);
    end
    check(p_sa, a);
    check(p_sp, ex);
    if (f[0])
      check(p_sd, d);
    else
      check({got, mrd}, {1'b1, ~a, a});
  endtask
  // one access by an outside master; s = read, write-low, write-high strobes
  task automatic s_acc(input logic [31:0] a, input logic [2:0] s, input logic b);
    logic [63:0] d;
    rng = xs();
    d = {rng, ~rng};
    ea = (!b && pb) ? ea + 32'h1 : a;
    pb = !b;
    @(posedge clk_sys);
    ta <= a;
    td <= d;
    tdoe <= s[2];
    {trd, twl, twh} <= s;
    tbr <= b;
    wait_lvl(1, 1'b0);
    if (!s[2])
      check(d_w, {~ea, ea});
    else
      q.push_back({ea, d, !s[1], !s[0]});
    @(posedge clk_sys);
    {trd, twl, twh} <= 3'h7;
    wait_lvl(2, 1'b0);
  endtask
  // reset and strap, master cycles, release of the bus, slave accesses
  initial
  begin
    rng = xs();
    tbms = rng[0];
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    check(oes, 6'h00);
    @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (4) @(posedge clk_sys);
    check(strap, tbms);
    for (int i = 0; i < 6; i++)
      m_xfer(ca[i], cf[i]);
    $display("master cycles done");
    @(posedge clk_sys);
    hgn <= 1'b0;
    repeat (6) @(negedge clk_sys);
    check(oes, 6'h00);
    @(posedge clk_sys);
    hgn <= 1'b1;
    own <= 1'b0;
    toe <= 1'b1;
    repeat (6) @(negedge clk_sys);
    check(oes, 6'h00);
    $display("bus release done");
    s_acc(32'h40, 3'h5, 1'b1);
    s_acc(32'h50, 3'h4, 1'b0);
    s_acc(32'h1234, 3'h4, 1'b0);
    s_acc(32'h60, 3'h3, 1'b1);
    s_acc(32'h70, 3'h3, 1'b0);
    s_acc(32'h1234, 3'h3, 1'b0);
    while (q.size() > 0)
    begin
      @(negedge clk_sys);
      check({swv, swa, swd, swl, swh}, {1'b1, q.pop_front()});
      @(posedge clk_sys);
      swr <= 1'b1;
      @(posedge clk_sys);
      swr <= 1'b0;
    end
    $display("slave accesses done");
    finish_test();
  end
endmodule // tb_ebp_port
`default_nettype wire
